// [efs_pkg.sv]
// Constants for the Ethernet frame statistics counter bank
package efs_pkg;

  localparam int DATA_W = 32;
  localparam int LEN_W  = 16;
  localparam int N_CNT  = 9;
  localparam int N_OCT  = 3;

  // Register byte offsets
  localparam logic [15:0] OFF_GOOD_TX_PACKET_COUNT  = 16'h4080;
  localparam logic [15:0] OFF_GOOD_RX_OCTETS_LOW    = 16'h4088;
  localparam logic [15:0] OFF_GOOD_RX_OCTETS_HIGH   = 16'h408c;
  localparam logic [15:0] OFF_GOOD_TX_OCTETS_LOW    = 16'h4090;
  localparam logic [15:0] OFF_GOOD_TX_OCTETS_HIGH   = 16'h4094;
  localparam logic [15:0] OFF_RX_NO_BUFFER_COUNT    = 16'h40a0;
  localparam logic [15:0] OFF_RX_UNDERSIZE_COUNT    = 16'h40a4;
  localparam logic [15:0] OFF_RX_FRAGMENT_COUNT     = 16'h40a8;
  localparam logic [15:0] OFF_RX_OVERSIZE_COUNT     = 16'h40ac;
  localparam logic [15:0] OFF_RX_JABBER_COUNT       = 16'h40b0;
  localparam logic [15:0] OFF_MGMT_RX_PACKET_COUNT  = 16'h40b4;
  localparam logic [15:0] OFF_MGMT_DROPPED_COUNT    = 16'h40b8;
  localparam logic [15:0] OFF_MGMT_TX_PACKET_COUNT  = 16'h40bc;
  localparam logic [15:0] OFF_TOTAL_RX_OCTETS_LOW   = 16'h40c0;
  localparam logic [15:0] OFF_TOTAL_RX_OCTETS_HIGH  = 16'h40c4;
  localparam logic [15:0] OFF_STAT_CTRL             = 16'h40f8;

  // Control register fields and reset value
  localparam int          CTRL_RX_EN_BIT = 0;
  localparam int          CTRL_TX_EN_BIT = 1;
  localparam int          CTRL_LPE_BIT   = 2;
  localparam int          CTRL_W         = 3;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;

  // 32-bit counter indices
  localparam int C_GOOD_TX = 0;
  localparam int C_NO_BUF  = 1;
  localparam int C_UNDER   = 2;
  localparam int C_FRAG    = 3;
  localparam int C_OVER    = 4;
  localparam int C_JABBER  = 5;
  localparam int C_MGMT_RX = 6;
  localparam int C_MGMT_DR = 7;
  localparam int C_MGMT_TX = 8;

  // 64-bit octet counter indices
  localparam int O_GOOD_RX  = 0;
  localparam int O_GOOD_TX  = 1;
  localparam int O_TOTAL_RX = 2;

  // Decoded register selector
  localparam logic [4:0] SEL_OCT_BASE = 5'h09;
  localparam logic [4:0] SEL_CTRL     = 5'h0f;
  localparam logic [4:0] SEL_NONE     = 5'h1f;

  // Frame length limits in bytes
  localparam logic [15:0] LEN_MIN       = 16'h0040;
  localparam logic [15:0] LEN_MAX_STD   = 16'h05f2;
  localparam logic [15:0] LEN_MAX_LONG  = 16'h4000;
  localparam logic [15:0] LEN_JAB_LONG  = 16'h3fff;
  localparam logic [15:0] LEN_MGMT_MAX  = 16'h00c8;

  localparam logic [31:0] CNT_RESET = 32'h0000_0000;
  localparam logic [63:0] OCT_RESET = 64'h0000_0000_0000_0000;
  localparam logic [63:0] OCT_MAX   = 64'hffff_ffff_ffff_ffff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : efs_pkg

// [efs_stat_counters.sv]
// Ethernet frame statistics counter bank with AXI4-Lite register slave
`timescale 1ns/1ps

module efs_stat_counters #(
  parameter int ADDR_W = 16
) (
  // Clock, reset, clock enable
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [efs_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic [efs_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Receive frame report from the MAC, one pulse per frame
  input  wire logic                        rx_frame_valid,
  input  wire logic [efs_pkg::LEN_W-1:0]   rx_frame_len,
  input  wire logic                        rx_crc_ok,
  input  wire logic                        rx_addr_pass,
  input  wire logic                        rx_bcast_reject,
  input  wire logic                        rx_flow_ctrl,
  input  wire logic                        rx_desc_empty,
  input  wire logic                        mgmt_filter_pass,
  input  wire logic                        mgmt_fifo_full,
  // Transmit frame report from the MAC, one pulse per frame
  input  wire logic                        tx_frame_valid,
  input  wire logic [efs_pkg::LEN_W-1:0]   tx_frame_len,
  input  wire logic                        tx_ok,
  input  wire logic                        tx_flow_ctrl,
  input  wire logic                        tx_mgmt
);
  import efs_pkg::*;

  if (ADDR_W < 16 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 16 and 32");
  end

  // Maps a byte address to a register selector
  function automatic logic [4:0] decode(input logic [ADDR_W-1:0] a);
    logic [15:0] o;
    o = a[15:0];
    if (a[1:0] != 2'h0 || (ADDR_W > 16 && |(a >> 16))) begin
      return SEL_NONE;
    end
    unique case (o)
      OFF_GOOD_TX_PACKET_COUNT: return 5'(C_GOOD_TX);
      OFF_RX_NO_BUFFER_COUNT:   return 5'(C_NO_BUF);
      OFF_RX_UNDERSIZE_COUNT:   return 5'(C_UNDER);
      OFF_RX_FRAGMENT_COUNT:    return 5'(C_FRAG);
      OFF_RX_OVERSIZE_COUNT:    return 5'(C_OVER);
      OFF_RX_JABBER_COUNT:      return 5'(C_JABBER);
      OFF_MGMT_RX_PACKET_COUNT: return 5'(C_MGMT_RX);
      OFF_MGMT_DROPPED_COUNT:   return 5'(C_MGMT_DR);
      OFF_MGMT_TX_PACKET_COUNT: return 5'(C_MGMT_TX);
      OFF_GOOD_RX_OCTETS_LOW:   return SEL_OCT_BASE;
      OFF_GOOD_RX_OCTETS_HIGH:  return SEL_OCT_BASE + 5'h01;
      OFF_GOOD_TX_OCTETS_LOW:   return SEL_OCT_BASE + 5'h02;
      OFF_GOOD_TX_OCTETS_HIGH:  return SEL_OCT_BASE + 5'h03;
      OFF_TOTAL_RX_OCTETS_LOW:  return SEL_OCT_BASE + 5'h04;
      OFF_TOTAL_RX_OCTETS_HIGH: return SEL_OCT_BASE + 5'h05;
      OFF_STAT_CTRL:            return SEL_CTRL;
      default:                  return SEL_NONE;
    endcase
  endfunction : decode

  // Storage
  logic [31:0]       cnt [N_CNT];
  logic [63:0]       oct [N_OCT];
  logic [CTRL_W-1:0] ctrl;

  // Event qualification
  logic              rx_en;
  logic              tx_en;
  logic              long_packet_enable;
  logic [15:0]       over_lim;
  logic [15:0]       jab_lim;
  logic              rx_short;
  logic              rx_over;
  logic              rx_jab;
  logic [N_CNT-1:0]  inc;
  logic [N_OCT-1:0]  oct_add;
  logic [15:0]       oct_len [N_OCT];
  logic [N_OCT-1:0]  oct_clr;

  // Bus side
  logic [4:0]        ar_sel;
  logic              ar_take;
  logic [31:0]       next_rdata;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              wr_do;
  logic [4:0]        aw_sel;

  assign rx_en = ctrl[CTRL_RX_EN_BIT];
  assign tx_en = ctrl[CTRL_TX_EN_BIT];
  assign long_packet_enable   = ctrl[CTRL_LPE_BIT];

  // Long packets move both size limits; with them jabber uses one byte less, without them both limits are equal
  assign over_lim = long_packet_enable ? LEN_MAX_LONG : LEN_MAX_STD;
  assign jab_lim  = long_packet_enable ? LEN_JAB_LONG : LEN_MAX_STD;
  assign rx_short = rx_frame_len < LEN_MIN;
  assign rx_over  = rx_frame_len > over_lim;
  assign rx_jab   = rx_frame_len > jab_lim;

  // Per-frame events; lengths already span address through CRC
  always_comb begin
    inc     = '0;
    oct_add = '0;
    if (rx_frame_valid && rx_en) begin
      inc[C_NO_BUF] = !rx_flow_ctrl && rx_desc_empty;
      inc[C_UNDER]  = rx_addr_pass && rx_short && rx_crc_ok;
      inc[C_FRAG]   = rx_addr_pass && rx_short && !rx_crc_ok;
      inc[C_OVER]   = rx_addr_pass && rx_over;
      inc[C_JABBER] = rx_addr_pass && rx_jab && !rx_crc_ok;
      oct_add[O_GOOD_RX] = rx_addr_pass && rx_crc_ok && !rx_flow_ctrl
                           && !rx_short && !rx_over;
      oct_add[O_TOTAL_RX] = rx_addr_pass || rx_bcast_reject;
    end
    // Management filters sit beside the host path, so no enable applies
    if (rx_frame_valid && mgmt_filter_pass) begin
      inc[C_MGMT_RX] = !rx_flow_ctrl && rx_crc_ok;
      inc[C_MGMT_DR] = mgmt_fifo_full || (rx_frame_len > LEN_MGMT_MAX);
    end
    // No secure qualifier: clear and secured frames count the same
    if (tx_frame_valid && tx_en && tx_ok) begin
      inc[C_GOOD_TX] = !tx_flow_ctrl && (tx_frame_len >= LEN_MIN);
      oct_add[O_GOOD_TX] = !tx_flow_ctrl && (tx_frame_len >= LEN_MIN);
    end
    if (tx_frame_valid && tx_ok) begin
      inc[C_MGMT_TX] = tx_mgmt;
    end
  end

  assign oct_len[O_GOOD_RX]  = rx_frame_len;
  assign oct_len[O_TOTAL_RX] = rx_frame_len;
  assign oct_len[O_GOOD_TX]  = tx_frame_len;

  // Event counters wrap; only the octet counters saturate
  for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt[i] <= CNT_RESET;
      end else if (ce && inc[i]) begin
        cnt[i] <= cnt[i] + 32'h0000_0001;
      end
    end
  end

  // Octet counters: clear on upper-half read, saturate otherwise
  for (genvar k = 0; k < N_OCT; k++) begin : g_oct
    logic [64:0] sum;
    assign sum = {1'b0, oct[k]} + {49'h0, oct_len[k]};
    assign oct_clr[k] = ar_take && (ar_sel == SEL_OCT_BASE + 5'(2 * k + 1));
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        oct[k] <= OCT_RESET;
      end else if (ce) begin
        if (oct_clr[k]) begin
          oct[k] <= OCT_RESET;
        end else if (oct_add[k]) begin
          oct[k] <= sum[64] ? OCT_MAX : sum[63:0];
        end
      end
    end
  end

  // Read channel: one outstanding read, answered one cycle after it is taken
  assign ar_sel  = decode(s_axi_araddr);
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (ar_sel < 5'(N_CNT)) begin
      next_rdata = cnt[ar_sel[3:0]];
    end else if (ar_sel == SEL_CTRL) begin
      next_rdata = {29'h0, ctrl};
    end else if (ar_sel != SEL_NONE) begin
      // Low word read leaves the counter untouched
      unique case (ar_sel - SEL_OCT_BASE)
        5'h00: next_rdata = oct[O_GOOD_RX][31:0];
        5'h01: next_rdata = oct[O_GOOD_RX][63:32];
        5'h02: next_rdata = oct[O_GOOD_TX][31:0];
        5'h03: next_rdata = oct[O_GOOD_TX][63:32];
        5'h04: next_rdata = oct[O_TOTAL_RX][31:0];
        5'h05: next_rdata = oct[O_TOTAL_RX][63:32];
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= (ar_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Write channel: address and data are taken in either order and held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_addr       <= '0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr       <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  assign aw_sel = decode(aw_addr);
  assign wr_do  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Counters are read-only; writes to them are accepted and dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (ce && wr_do && aw_sel == SEL_CTRL && w_strb[0]) begin
      ctrl <= w_data[CTRL_W-1:0];
    end
  end

endmodule : efs_stat_counters

// [efs_stat_counters_checker.sv]
// Bus protocol checker for the statistics counter bank
`timescale 1ns/1ps

module efs_checker
  import efs_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  // Read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  // Write channels
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce
    |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read dropped");
  rd_release_a: assert property (s_axi_rvalid && s_axi_rready && ce
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not released");
  bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && ce && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unaligned read ok");
  cnt_addr_a: assert property (s_axi_arvalid && s_axi_arready && ce
    && s_axi_araddr == ADDR_W'(OFF_GOOD_TX_PACKET_COUNT) |=> s_axi_rresp == RESP_OKAY)
    else $error("counter read refused");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && ce |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid) else $error("write answer late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  wr_release_a: assert property (s_axi_bvalid && s_axi_bready && ce
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not released");
  reset_out_a: assert property ($rose(aresetn)
    |-> s_axi_arready && s_axi_awready && !s_axi_rvalid && !s_axi_bvalid) else $error("reset state");
endmodule : efs_checker

bind efs_stat_counters efs_checker #(
  .ADDR_W (ADDR_W)
) u_chk (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .ce            (ce),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_wvalid  (s_axi_wvalid),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready)
);

// [efs_mac_model.sv]
// Behavioural MAC frame reporter feeding the counter bank
`timescale 1ns/1ps

module efs_mac_model (
  // Clock
  input  wire logic  aclk,
  // Receive report: crc, addr, bcast, flow, desc, mfilt, mfull
  output logic        rx_frame_valid,
  output logic [15:0] rx_frame_len,
  output logic [6:0]  rx_flags,
  // Transmit report: ok, flow, mgmt
  output logic        tx_frame_valid,
  output logic [15:0] tx_frame_len,
  output logic [2:0]  tx_flags
);
  initial begin
    rx_frame_valid = 1'b0;
    tx_frame_valid = 1'b0;
    rx_frame_len = 16'h0;
    tx_frame_len = 16'h0;
    rx_flags = 7'h0;
    tx_flags = 3'h0;
  end

  // Idle qualifiers show the inverse so a stale value never looks live
  task automatic rx(input logic [15:0] l, input logic [6:0] f);
    @(posedge aclk);
    rx_frame_valid <= 1'b1;
    rx_frame_len <= l;
    rx_flags <= f;
    @(posedge aclk);
    rx_frame_valid <= 1'b0;
    rx_frame_len <= ~l;
    rx_flags <= ~f;
  endtask : rx

  task automatic tx(input logic [15:0] l, input logic [2:0] f);
    @(posedge aclk);
    tx_frame_valid <= 1'b1;
    tx_frame_len <= l;
    tx_flags <= f;
    @(posedge aclk);
    tx_frame_valid <= 1'b0;
    tx_frame_len <= ~l;
    tx_flags <= ~f;
  endtask : tx
endmodule : efs_mac_model

// [efs_stat_counters_tb_top.sv]
// Self-checking bench for the statistics counter bank
`timescale 1ns/1ps

module efs_stat_counters_tb_top;
  import efs_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic [15:0] awaddr = 0, araddr = 0, rxl, txl;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid, rxv, txv;
  logic [1:0] bresp, rresp;
  logic [6:0] rxf;
  logic [2:0] txf;
  logic ce = 1'b1;
  logic [3:0] wstrb = 4'hf;
  int errors = 0, total_checks = 0;

  always #25 aclk = ~aclk;

  efs_mac_model mac (.aclk(aclk), .rx_frame_valid(rxv), .rx_frame_len(rxl), .rx_flags(rxf),
    .tx_frame_valid(txv), .tx_frame_len(txl), .tx_flags(txf));

  efs_stat_counters DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_frame_valid(rxv), .rx_frame_len(rxl), .rx_crc_ok(rxf[6]), .rx_addr_pass(rxf[5]),
    .rx_bcast_reject(rxf[4]), .rx_flow_ctrl(rxf[3]), .rx_desc_empty(rxf[2]),
    .mgmt_filter_pass(rxf[1]), .mgmt_fifo_full(rxf[0]), .tx_frame_valid(txv),
    .tx_frame_len(txl), .tx_ok(txf[2]), .tx_flow_ctrl(txf[1]), .tx_mgmt(txf[0]));

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic hang(input int n);
    if (n >= 40) begin
      errors++;
      summarize();
    end
  endtask : hang

  // Ready is raised only once the answer shows, so the hold phase is exercised
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    n = 0;
    do begin @(posedge aclk); n++; end while (!arready && n < 40);
    arvalid <= 1'b0;
    hang(n);
    n = 0;
    do begin @(posedge aclk); n++; end while (!rvalid && n < 40);
    hang(n);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Address and data are each released at their own acceptance edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    int n;
    bit aw_done;
    bit w_done;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    do begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end while (!(aw_done && w_done) && n < 40);
    hang(n);
    n = 0;
    do begin @(posedge aclk); n++; end while (!bvalid && n < 40);
    hang(n);
    bready <= 1'b1;
    @(posedge aclk);
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    bready <= 1'b0;
  endtask : wr

  task automatic ck(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask : ck

  task automatic t_reset;
    for (int a = 'h4080; a <= 'h40c4; a += 4)
      ck(16'(a), 32'h0, (a == 'h4084 || a == 'h4098 || a == 'h409c) ? RESP_SLVERR : RESP_OKAY);
    ck(OFF_STAT_CTRL, 32'h0);
    ck(16'h4081, 32'h0, RESP_SLVERR);
    wr(OFF_RX_UNDERSIZE_COUNT, 32'h5);
    ck(OFF_RX_UNDERSIZE_COUNT, 32'h0);
  endtask : t_reset

  // Traffic with both directions disabled must leave the gated counters alone
  task automatic t_gate;
    mac.rx(16'd100, 7'b1100000);
    mac.tx(16'd100, 3'b100);
    mac.tx(16'd64, 3'b101);
    ck(OFF_GOOD_TX_PACKET_COUNT, 32'h0);
    ck(OFF_GOOD_TX_OCTETS_LOW, 32'h0);
    ck(OFF_GOOD_RX_OCTETS_LOW, 32'h0);
    ck(OFF_TOTAL_RX_OCTETS_LOW, 32'h0);
    ck(OFF_MGMT_TX_PACKET_COUNT, 32'h1);
    wr(OFF_STAT_CTRL, 32'hffff_fffb);
    ck(OFF_STAT_CTRL, 32'h3);
    wstrb <= 4'he;
    wr(OFF_STAT_CTRL, 32'h0);
    wstrb <= 4'hf;
    ck(OFF_STAT_CTRL, 32'h3);
  endtask : t_gate

  task automatic t_rx;
    mac.rx(16'd64, 7'b1100000);
    mac.rx(16'd64, 7'b1101000);
    mac.rx(16'd70, 7'b0010000);
    mac.rx(16'd63, 7'b1100000);
    mac.rx(16'd63, 7'b0100000);
    mac.rx(16'd1523, 7'b1100000);
    mac.rx(16'd1522, 7'b1100000);
    mac.rx(16'd1523, 7'b0100000);
    mac.rx(16'd64, 7'b1100100);
    mac.rx(16'd64, 7'b1101100);
    mac.rx(16'd500, 7'b1000000);
    ck(OFF_GOOD_RX_OCTETS_LOW, 32'd1650);
    ck(OFF_GOOD_RX_OCTETS_LOW, 32'd1650);
    ck(OFF_GOOD_RX_OCTETS_HIGH, 32'h0);
    ck(OFF_GOOD_RX_OCTETS_LOW, 32'h0);
    ck(OFF_TOTAL_RX_OCTETS_LOW, 32'd5020);
    ck(OFF_TOTAL_RX_OCTETS_HIGH, 32'h0);
    ck(OFF_TOTAL_RX_OCTETS_LOW, 32'h0);
    ck(OFF_RX_UNDERSIZE_COUNT, 32'h1);
    ck(OFF_RX_FRAGMENT_COUNT, 32'h1);
    ck(OFF_RX_NO_BUFFER_COUNT, 32'h1);
    wr(OFF_STAT_CTRL, 32'h7);
    mac.rx(16'd1523, 7'b0100000);
    mac.rx(16'd16384, 7'b1100000);
    mac.rx(16'd16385, 7'b1100000);
    mac.rx(16'd16384, 7'b0100000);
    ck(OFF_RX_OVERSIZE_COUNT, 32'h3);
    ck(OFF_RX_JABBER_COUNT, 32'h2);
  endtask : t_rx

  task automatic t_mgmt;
    mac.rx(16'd100, 7'b1100010);
    mac.rx(16'd100, 7'b1100011);
    mac.rx(16'd201, 7'b1100010);
    mac.rx(16'd200, 7'b1100010);
    mac.rx(16'd100, 7'b0100010);
    mac.rx(16'd100, 7'b1101010);
    ck(OFF_MGMT_RX_PACKET_COUNT, 32'h4);
    ck(OFF_MGMT_DROPPED_COUNT, 32'h2);
  endtask : t_mgmt

  task automatic t_tx;
    mac.tx(16'd64, 3'b100);
    mac.tx(16'd63, 3'b100);
    mac.tx(16'd64, 3'b110);
    mac.tx(16'd1000, 3'b000);
    mac.tx(16'd1000, 3'b100);
    mac.tx(16'd64, 3'b101);
    mac.tx(16'd64, 3'b001);
    ck(OFF_GOOD_TX_PACKET_COUNT, 32'h3);
    ck(OFF_GOOD_TX_OCTETS_LOW, 32'd1128);
    ck(OFF_MGMT_TX_PACKET_COUNT, 32'h2);
    ck(OFF_GOOD_TX_OCTETS_HIGH, 32'h0);
    ck(OFF_GOOD_TX_OCTETS_LOW, 32'h0);
  endtask : t_tx

  // Clearing read and frame land on one edge; then a frame under a frozen clock enable
  task automatic t_edge;
    fork
      ck(OFF_TOTAL_RX_OCTETS_HIGH, 32'h0);
      mac.rx(16'd64, 7'b1100000);
    join
    ck(OFF_TOTAL_RX_OCTETS_LOW, 32'h0);
    ck(OFF_GOOD_RX_OCTETS_HIGH, 32'h0);
    @(posedge aclk);
    ce <= 1'b0;
    mac.rx(16'd64, 7'b1100000);
    @(posedge aclk);
    ce <= 1'b1;
    ck(OFF_GOOD_RX_OCTETS_LOW, 32'h0);
    mac.rx(16'd64, 7'b1100000);
    ck(OFF_GOOD_RX_OCTETS_LOW, 32'd64);
  endtask : t_edge

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_gate();
    t_rx();
    t_mgmt();
    t_tx();
    t_edge();
    summarize();
  end
endmodule : efs_stat_counters_tb_top
